/* core/cam_pwr_defs.svh */
// constants for the camera power sequencing model: offsets, values, counts
// assumes a 100 MHz core_clk standing in for the reference clock
`ifndef CAM_PWR_DEFS_SVH
`define CAM_PWR_DEFS_SVH
`define CLK_PERIOD_NS 10
`define REF_MIN_MHZ 16'h0006
`define REF_MAX_MHZ 16'h001B
`define REG_MODE_CTRL 16'h0100
`define REG_SOFT_RESET 16'h0103
`define REG_REF_FREQ 16'h0136
`define MODE_STREAM 8'h01
`define MODE_STANDBY 8'h00
`define SOFT_RESET_GO 8'h01
`define REF_FREQ_RESET 16'h0000
`define WAKE_CYCLES 2400
`define QUIET_CYCLES 512
`define PLL_LOCK_MS 1
`define PLL_LOCK_CYC ((`PLL_LOCK_MS * 1000000) / `CLK_PERIOD_NS)
`define FIRST_FRAME_FIXED 64
`define FRAME_CYCLES 1024
// host command register offsets
`define HOST_CTRL 4'h0
`define HOST_STATUS 4'h1
`define HOST_ADDR 4'h2
`define HOST_WDATA 4'h3
`define HOST_RDATA 4'h4
`define HOST_INTEG 4'h5
`endif

/* core/cam_pwr_pkg.sv */
// types for the two ends of the camera power sequencing link: device modes, host states
// assumes nothing beyond the defs header
package cam_pwr_pkg;
    typedef enum logic [1:0] {HW_STANDBY, SW_STANDBY, STREAMING,
        STOPPING} dev_mode_t;
    typedef enum logic [2:0] {H_OFF, H_RAIL_A, H_RAIL_B, H_WAKE, H_READY,
        H_BUS, H_QUIET, H_DOWN} host_state_t;
endpackage

/* core/cam_pwr_if.sv */
// link between host sequencer and camera device: rails, power_down_n,
// reference clock gate, and a simple control-bus transaction port
// assumes the testbench drives core_clk and rst_b to both ends
`timescale 1ns/1ps
interface cam_pwr_if;
    logic digital_supply;
    logic analog_supply;
    logic power_down_n;
    logic ref_clk_en;
    logic bus_req;
    logic bus_we;
    logic [15:0] bus_addr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic bus_ack;
    logic frame_end;
    modport host (output digital_supply, analog_supply, power_down_n,
        ref_clk_en, bus_req, bus_we, bus_addr, bus_wdata,
        input bus_rdata, bus_ack, frame_end);
    modport dev (input digital_supply, analog_supply, power_down_n,
        ref_clk_en, bus_req, bus_we, bus_addr, bus_wdata,
        output bus_rdata, bus_ack, frame_end);
endinterface

/* core/cam_dev.sv */
// camera device end: power-on reset, pll lock, mode control, first frame
// assumes link pins come from another module on core_clk (no synchroniser)
`timescale 1ns/1ps
`include "cam_pwr_defs.svh"
module cam_dev #(
    parameter int PLL_LOCK_CYC = `PLL_LOCK_CYC,
    parameter int FRAME_CYC = `FRAME_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    cam_pwr_if.dev link,
    input wire logic [15:0] integ_time,
    output logic pll_locked,
    output logic streaming,
    output logic data_out_en,
    output logic frame_start,
    output logic [1:0] mode
);
    cam_pwr_pkg::dev_mode_t mode_ff;
    logic por_n;
    logic soft_rst;
    logic [7:0] mode_reg_ff;
    logic [15:0] ref_freq_ff;
    logic [31:0] pll_cnt_ff;
    logic pll_lock_ff;
    logic [31:0] frm_cnt_ff;
    logic first_ff;
    logic fs_ff;
    logic fe_ff;
    logic [15:0] rdata_ff;
    logic ack_ff;
    logic freq_ok;
    logic wr;

    // rails and power-down together form the internal reset
    assign por_n = link.digital_supply & link.analog_supply
        & link.power_down_n;
    assign wr = link.bus_req & link.bus_we & por_n;
    assign soft_rst = wr && link.bus_addr == `REG_SOFT_RESET
        && link.bus_wdata[7:0] == `SOFT_RESET_GO;
    assign freq_ok = ref_freq_ff >= `REF_MIN_MHZ
        && ref_freq_ff <= `REF_MAX_MHZ;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_reg_ff <= `MODE_STANDBY;
            ref_freq_ff <= `REF_FREQ_RESET;
        end
        else if (!por_n || soft_rst)
        begin
            mode_reg_ff <= `MODE_STANDBY;
            ref_freq_ff <= `REF_FREQ_RESET;
        end
        else if (wr && link.bus_addr == `REG_MODE_CTRL)
            mode_reg_ff <= link.bus_wdata[7:0];
        else if (wr && link.bus_addr == `REG_REF_FREQ)
            ref_freq_ff <= link.bus_wdata;
    end

    // pll lock counted only while reference clock runs in range
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pll_cnt_ff <= 32'h00000000;
            pll_lock_ff <= 1'b0;
        end
        else if (!por_n || soft_rst || !link.ref_clk_en || !freq_ok)
        begin
            pll_cnt_ff <= 32'h00000000;
            pll_lock_ff <= 1'b0;
        end
        else if (pll_cnt_ff >= 32'(PLL_LOCK_CYC - 1))
            pll_lock_ff <= 1'b1;
        else
            pll_cnt_ff <= pll_cnt_ff + 32'h00000001;
    end

    // frame timer: first frame waits fixed part plus integration time
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_ff <= cam_pwr_pkg::HW_STANDBY;
            frm_cnt_ff <= 32'h00000000;
            first_ff <= 1'b0;
            fs_ff <= 1'b0;
            fe_ff <= 1'b0;
        end
        else if (!por_n)
        begin
            mode_ff <= cam_pwr_pkg::HW_STANDBY;
            frm_cnt_ff <= 32'h00000000;
            fs_ff <= 1'b0;
            fe_ff <= 1'b0;
        end
        else
        begin
            fs_ff <= 1'b0;
            fe_ff <= 1'b0;
            case (mode_ff)
                cam_pwr_pkg::HW_STANDBY:
                    mode_ff <= cam_pwr_pkg::SW_STANDBY;
                cam_pwr_pkg::SW_STANDBY:
                begin
                    frm_cnt_ff <= 32'h00000000;
                    if (mode_reg_ff == `MODE_STREAM && pll_lock_ff
                        && !soft_rst)
                    begin
                        mode_ff <= cam_pwr_pkg::STREAMING;
                        first_ff <= 1'b1;
                    end
                end
                cam_pwr_pkg::STREAMING, cam_pwr_pkg::STOPPING:
                begin
                    if (first_ff)
                    begin
                        if (frm_cnt_ff >= 32'(`FIRST_FRAME_FIXED)
                            + 32'(integ_time))
                        begin
                            first_ff <= 1'b0;
                            frm_cnt_ff <= 32'h00000000;
                            fs_ff <= 1'b1;
                        end
                        else
                            frm_cnt_ff <= frm_cnt_ff + 32'h00000001;
                    end
                    else if (frm_cnt_ff >= 32'(FRAME_CYC - 1))
                    begin
                        frm_cnt_ff <= 32'h00000000;
                        fe_ff <= 1'b1;
                        // standby only at frame boundary, except when streaming stops before the first frame starts
                        if (mode_ff == cam_pwr_pkg::STOPPING)
                            mode_ff <= cam_pwr_pkg::SW_STANDBY;
                        else
                            fs_ff <= 1'b1;
                    end
                    else
                        frm_cnt_ff <= frm_cnt_ff + 32'h00000001;
                    if (mode_ff == cam_pwr_pkg::STREAMING
                        && (mode_reg_ff != `MODE_STREAM || soft_rst))
                    begin
                        if (first_ff)
                            mode_ff <= cam_pwr_pkg::SW_STANDBY;
                        else
                            mode_ff <= cam_pwr_pkg::STOPPING;
                    end
                end
                default:
                    mode_ff <= cam_pwr_pkg::HW_STANDBY;
            endcase
        end
    end

    // bus answers one cycle after the request; none in hardware standby
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= 16'h0000;
        end
        else
        begin
            ack_ff <= link.bus_req & por_n;
            if (link.bus_req && !link.bus_we)
            begin
                case (link.bus_addr)
                    `REG_MODE_CTRL: rdata_ff <= {8'h00, mode_reg_ff};
                    `REG_REF_FREQ: rdata_ff <= ref_freq_ff;
                    default: rdata_ff <= 16'h0000;
                endcase
            end
        end
    end

    assign link.bus_ack = ack_ff;
    assign link.bus_rdata = rdata_ff;
    assign link.frame_end = fe_ff;
    assign pll_locked = pll_lock_ff;
    assign streaming = mode_ff == cam_pwr_pkg::STREAMING;
    // outputs stay driven through the last frame while stopping
    assign data_out_en = (mode_ff == cam_pwr_pkg::STREAMING
        || mode_ff == cam_pwr_pkg::STOPPING) && !first_ff;
    assign frame_start = fs_ff;
    assign mode = mode_ff;
endmodule

/* core/cam_host.sv */
// host sequencer end: rails, power-down, reference clock gate, bus master
// assumes software reaches it over a plain address/strobe register port
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "cam_pwr_defs.svh"
module cam_host #(
    parameter int WAKE_CYC = `WAKE_CYCLES,
    parameter int QUIET_CYC = `QUIET_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    cam_pwr_if.host link,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    output logic [15:0] integ_time
);
    cam_pwr_pkg::host_state_t st_ff;
    logic [1:0] ctrl_ff;
    logic [15:0] baddr_ff;
    logic [15:0] bwdata_ff;
    logic [15:0] brdata_ff;
    logic [15:0] integ_ff;
    logic go_ff;
    logic we_ff;
    logic busy_ff;
    logic [15:0] wait_ff;
    logic [15:0] rd_ff;
    logic fe_sync1_ff;
    logic fe_sync2_ff;
    logic ack_s1_ff;
    logic ack_s2_ff;

    // ctrl bit0: power on, bit1: reference clock enable
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_ff <= 2'h0;
            baddr_ff <= 16'h0000;
            bwdata_ff <= 16'h0000;
            integ_ff <= 16'h0000;
        end
        else if (wr_stb)
        begin
            case (addr)
                `HOST_CTRL: ctrl_ff <= wdata[1:0];
                `HOST_ADDR: baddr_ff <= wdata;
                `HOST_WDATA: bwdata_ff <= wdata;
                `HOST_INTEG: integ_ff <= wdata;
                default: ;
            endcase
        end
    end

    // frame_end and bus_ack come from the device and pass two flops; bus_rdata does not
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fe_sync1_ff <= 1'b0;
            fe_sync2_ff <= 1'b0;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end
        else
        begin
            fe_sync1_ff <= link.frame_end;
            fe_sync2_ff <= fe_sync1_ff;
            ack_s1_ff <= link.bus_ack;
            ack_s2_ff <= ack_s1_ff;
        end
    end

    // transaction request: write to status register, bit0 write, bit1 read
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            go_ff <= 1'b0;
            we_ff <= 1'b0;
        end
        else if (wr_stb && addr == `HOST_STATUS && !go_ff)
        begin
            go_ff <= wdata[0] | wdata[1];
            we_ff <= wdata[0];
        end
        else if (st_ff == cam_pwr_pkg::H_BUS && ack_s2_ff)
            go_ff <= 1'b0;
    end

    // sequencer: rails, release, wake count, quiet count, power-down
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= cam_pwr_pkg::H_OFF;
            wait_ff <= 16'h0000;
            busy_ff <= 1'b0;
            brdata_ff <= 16'h0000;
        end
        else
        begin
            case (st_ff)
                cam_pwr_pkg::H_OFF:
                    if (ctrl_ff[0])
                        st_ff <= cam_pwr_pkg::H_RAIL_A;
                cam_pwr_pkg::H_RAIL_A:
                    st_ff <= cam_pwr_pkg::H_RAIL_B;
                cam_pwr_pkg::H_RAIL_B:
                begin
                    // both rails up before release
                    st_ff <= cam_pwr_pkg::H_WAKE;
                    wait_ff <= 16'h0000;
                end
                cam_pwr_pkg::H_WAKE:
                begin
                    // count only running reference edges
                    if (wait_ff >= 16'(WAKE_CYC - 1))
                        st_ff <= cam_pwr_pkg::H_READY;
                    else if (ctrl_ff[1])
                        wait_ff <= wait_ff + 16'h0001;
                end
                cam_pwr_pkg::H_READY:
                begin
                    if (!ctrl_ff[0])
                    begin
                        st_ff <= cam_pwr_pkg::H_QUIET;
                        wait_ff <= 16'h0000;
                    end
                    else if (go_ff && ctrl_ff[1])
                    begin
                        st_ff <= cam_pwr_pkg::H_BUS;
                        busy_ff <= 1'b1;
                    end
                end
                cam_pwr_pkg::H_BUS:
                begin
                    busy_ff <= 1'b0;
                    if (ack_s2_ff)
                    begin
                        brdata_ff <= rd_ff;
                        st_ff <= cam_pwr_pkg::H_READY;
                    end
                end
                cam_pwr_pkg::H_QUIET:
                begin
                    // frame end restarts the quiet wait
                    if (fe_sync2_ff)
                        wait_ff <= 16'h0000;
                    else if (wait_ff >= 16'(QUIET_CYC - 1))
                        st_ff <= cam_pwr_pkg::H_DOWN;
                    else
                        wait_ff <= wait_ff + 16'h0001;
                end
                cam_pwr_pkg::H_DOWN:
                    st_ff <= cam_pwr_pkg::H_OFF;
                default:
                    st_ff <= cam_pwr_pkg::H_OFF;
            endcase
        end
    end

    // read data captured from the device on its answer
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_ff <= 16'h0000;
        else if (link.bus_ack)
            rd_ff <= link.bus_rdata;
    end

    // power-down falls one state before rails drop
    assign link.digital_supply = st_ff != cam_pwr_pkg::H_OFF;
    assign link.analog_supply = st_ff != cam_pwr_pkg::H_OFF
        && st_ff != cam_pwr_pkg::H_RAIL_A;
    assign link.power_down_n = st_ff != cam_pwr_pkg::H_OFF
        && st_ff != cam_pwr_pkg::H_RAIL_A
        && st_ff != cam_pwr_pkg::H_RAIL_B
        && st_ff != cam_pwr_pkg::H_DOWN;
    // clock gate may start low and open in standby
    assign link.ref_clk_en = ctrl_ff[1] && link.digital_supply;
    assign link.bus_req = busy_ff;
    assign link.bus_we = we_ff;
    assign link.bus_addr = baddr_ff;
    assign link.bus_wdata = bwdata_ff;
    assign integ_time = integ_ff;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 16'h0000;
        else if (rd_stb)
        begin
            case (addr)
                `HOST_CTRL: rdata <= {14'h0000, ctrl_ff};
                `HOST_STATUS: rdata <= {12'h000, 1'b0, st_ff};
                `HOST_ADDR: rdata <= baddr_ff;
                `HOST_WDATA: rdata <= bwdata_ff;
                `HOST_RDATA: rdata <= brdata_ff;
                `HOST_INTEG: rdata <= integ_ff;
                default: rdata <= 16'h0000;
            endcase
        end
    end
endmodule

/* tb/cam_link_monitor.sv */
// link checker: rails, power_down_n, clock gate and control bus timing
// assumes every link signal is sampled on core_clk
`timescale 1ns/1ps
`include "cam_pwr_defs.svh"
module cam_link_monitor #(
    parameter int WAKE_CYC = `WAKE_CYCLES,
    parameter int QUIET_CYC = `QUIET_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic digital_supply,
    input wire logic analog_supply,
    input wire logic power_down_n,
    input wire logic ref_clk_en,
    input wire logic bus_req,
    input wire logic bus_ack,
    input wire logic frame_end
);
    logic [12:0] up_cnt_ff;
    logic [12:0] quiet_cnt_ff;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // counters saturate so a long idle spell cannot wrap into a false failure
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            up_cnt_ff <= 13'h0000;
        else if (!power_down_n)
            up_cnt_ff <= 13'h0000;
        else if (ref_clk_en && up_cnt_ff != 13'h1FFF)
            up_cnt_ff <= up_cnt_ff + 13'h0001;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            quiet_cnt_ff <= 13'h0000;
        else if (bus_ack || frame_end)
            quiet_cnt_ff <= 13'h0000;
        else if (quiet_cnt_ff != 13'h1FFF)
            quiet_cnt_ff <= quiet_cnt_ff + 13'h0001;
    end
    rails_first_a: assert property (
        power_down_n |-> digital_supply && analog_supply)
        else $error("power_down_n high without both rails");
    down_first_a: assert property (
        $fell(digital_supply) || $fell(analog_supply) |-> !power_down_n)
        else $error("rail fell while power_down_n high");
    wake_count_a: assert property (
        bus_req |-> up_cnt_ff >= WAKE_CYC)
        else $error("transaction too soon after wake");
    quiet_count_a: assert property (
        $fell(power_down_n) && $past(rst_b) |-> quiet_cnt_ff >= QUIET_CYC)
        else $error("power_down_n fell too soon after traffic");
    clock_on_bus_a: assert property (
        bus_req |-> ref_clk_en)
        else $error("transaction with reference clock stopped");
    no_comm_down_a: assert property (
        !power_down_n |-> !bus_ack && !frame_end)
        else $error("device active in hardware standby");
    ack_next_a: assert property (
        bus_req |=> bus_ack)
        else $error("transaction not acknowledged");
    frame_gap_a: assert property (
        frame_end |=> !frame_end [*8])
        else $error("frame cut short");
endmodule

/* tb/camera_power_sequence_tb.sv */
// testbench: host and device joined by the link, host driven by its port
// assumes the design files and their defs header are on the include path
`timescale 1ns/1ps
`include "cam_pwr_defs.svh"
module camera_power_sequence_tb;
    logic core_clk;
    logic rst_b;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic [15:0] rdata;
    logic [15:0] integ_time;
    logic pll_locked;
    logic streaming;
    logic data_out_en;
    logic frame_start;
    logic [1:0] mode;
    logic [15:0] rd_val;
    logic [15:0] freqs [3] = '{16'h0005, 16'h001C, 16'h0006};
    int n_errors;
    int compares;
    int cyc;
    int run_cnt;
    int first_gap;
    int t0;
    int k;
    cam_pwr_if cam_pwr_if_i ();
    cam_host cam_host_i (.core_clk(core_clk), .rst_b(rst_b),
        .link(cam_pwr_if_i), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .integ_time(integ_time));
    // short lock and frame counts keep the run brief
    cam_dev #(.PLL_LOCK_CYC(20), .FRAME_CYC(16)) cam_dev_i (
        .core_clk(core_clk), .rst_b(rst_b), .link(cam_pwr_if_i),
        .integ_time(integ_time), .pll_locked(pll_locked),
        .streaming(streaming), .data_out_en(data_out_en),
        .frame_start(frame_start), .mode(mode));
    cam_link_monitor #(.WAKE_CYC(`WAKE_CYCLES), .QUIET_CYC(`QUIET_CYCLES))
        cam_link_monitor_i (.core_clk(core_clk), .rst_b(rst_b),
        .digital_supply(cam_pwr_if_i.digital_supply),
        .analog_supply(cam_pwr_if_i.analog_supply),
        .power_down_n(cam_pwr_if_i.power_down_n),
        .ref_clk_en(cam_pwr_if_i.ref_clk_en),
        .bus_req(cam_pwr_if_i.bus_req), .bus_ack(cam_pwr_if_i.bus_ack),
        .frame_end(cam_pwr_if_i.frame_end));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        run_cnt <= (mode !== cam_pwr_pkg::STREAMING) ? 0 : run_cnt + 1;
        if (frame_start === 1'b1 && first_gap < 0)
            first_gap <= run_cnt;
        if (mode === cam_pwr_pkg::STOPPING && data_out_en !== 1'b1)
            err("video outputs floated mid-frame");
    end
    task err(input string msg);
        n_errors++;
        $display("wrong value at %0t ns: %s", $time, msg);
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
            err($sformatf("got %h expected %h", got, exp));
    endtask
    task chk_true(input logic c);
        chk({15'h0000, c}, 16'h0001);
    endtask
    task reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask
    task reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask
    task wait_state(input logic [2:0] s, input int lim);
        int i;
        i = 0;
        rd_val = 16'hFFFF;
        while (i < lim && rd_val[2:0] !== s)
        begin
            reg_rd(`HOST_STATUS, rd_val);
            i++;
        end
        chk({13'h0000, rd_val[2:0]}, {13'h0000, s});
    endtask
    task wait_dev(input logic [1:0] s, input int lim);
        int i;
        i = 0;
        while (i < lim && mode !== s)
        begin
            @(posedge core_clk);
            #1;
            i++;
        end
        chk({14'h0000, mode}, {14'h0000, s});
    endtask
    // one device access: address, data, go, then poll until idle again
    task dev_op(input logic we, input logic [15:0] a, input logic [15:0] d);
        reg_wr(`HOST_ADDR, a);
        reg_wr(`HOST_WDATA, d);
        reg_wr(`HOST_STATUS, we ? 16'h0001 : 16'h0002);
        repeat (2) @(posedge core_clk);
        wait_state(cam_pwr_pkg::H_READY, 20);
        if (!we)
            reg_rd(`HOST_RDATA, rd_val);
    endtask
    task complete_run();
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        err("run did not finish");
        complete_run();
    end
    initial
    begin
        n_errors = 0;
        compares = 0;
        cyc = 0;
        first_gap = -1;
        addr = 4'h0;
        wdata = 16'h0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        rst_b = 1'b0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        wait_dev(cam_pwr_pkg::HW_STANDBY, 1);
        wait_state(cam_pwr_pkg::H_OFF, 2);
        reg_rd(4'hF, rd_val);
        chk(rd_val, 16'h0000);
        reg_wr(`HOST_CTRL, 16'h0001);
        repeat (100) @(posedge core_clk);
        wait_state(cam_pwr_pkg::H_WAKE, 2);
        t0 = cyc;
        reg_wr(`HOST_CTRL, 16'h0003);
        wait_state(cam_pwr_pkg::H_READY, 1400);
        chk_true((cyc - t0) >= `WAKE_CYCLES);
        dev_op(1'b0, `REG_REF_FREQ, 16'h0000);
        chk(rd_val, `REF_FREQ_RESET);
        for (k = 0; k < 3; k++)
        begin
            dev_op(1'b1, `REG_REF_FREQ, freqs[k]);
            repeat (40) @(posedge core_clk);
            chk_true(pll_locked === (k == 2));
        end
        dev_op(1'b0, `REG_REF_FREQ, 16'h0000);
        chk(rd_val, 16'h0006);
        reg_wr(`HOST_INTEG, 16'h0005);
        dev_op(1'b1, `REG_MODE_CTRL, {8'h00, `MODE_STREAM});
        chk(integ_time, 16'h0005);
        t0 = 0;
        while (first_gap < 0 && t0 < 300)
        begin
            @(posedge core_clk);
            t0++;
        end
        #1;
        chk_true(first_gap >= `FIRST_FRAME_FIXED + 4);
        chk_true(first_gap <= `FIRST_FRAME_FIXED + 7);
        chk_true(streaming && data_out_en);
        dev_op(1'b1, `REG_MODE_CTRL, {8'h00, `MODE_STANDBY});
        wait_dev(cam_pwr_pkg::SW_STANDBY, 20);
        chk_true(data_out_en === 1'b0);
        dev_op(1'b1, `REG_SOFT_RESET, {8'h00, `SOFT_RESET_GO});
        dev_op(1'b0, `REG_REF_FREQ, 16'h0000);
        chk(rd_val, `REF_FREQ_RESET);
        wait_dev(cam_pwr_pkg::SW_STANDBY, 1);
        dev_op(1'b1, `REG_REF_FREQ, 16'h001B);
        repeat (30) @(posedge core_clk);
        chk_true(pll_locked);
        reg_wr(`HOST_CTRL, 16'h0000);
        wait_state(cam_pwr_pkg::H_OFF, 400);
        wait_dev(cam_pwr_pkg::HW_STANDBY, 1);
        chk_true(pll_locked === 1'b0);
        reg_wr(`HOST_CTRL, 16'h0003);
        wait_state(cam_pwr_pkg::H_READY, 1400);
        dev_op(1'b0, `REG_REF_FREQ, 16'h0000);
        chk(rd_val, `REF_FREQ_RESET);
        complete_run();
    end
endmodule
